// *** pkg/serial_port_consts.vh ***
// Constants for the display module serial host port
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define OP_WRITE        8'h44
`define OP_READ         8'h54
`define OP_STATUS       8'h58
`define READ_LEAD_BYTE  8'h00
`define EMPTY_READ_BYTE 8'hff
`define I2C_ADDR_BASE   7'h50
`define I2C_GENCALL     7'h00
`define STAT_BUSY_BIT   7
`define STAT_BAD_BIT    6
`define TL_MAX          7'd63
`define SPI_BUSY_AT     12'd54
`define SPI_READY_AT    12'd128
`define I2C_BUSY_AT     12'd62
`define I2C_READY_AT    12'd100
`define RX_DEPTH        2047
`define TX_DEPTH        127
`define INIT_DELAY_NS   100000
`define CLK_PERIOD_NS   100
`define INIT_CYCLES     ((`INIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** verilog/serial_host_port.v ***
// Serial host port: SPI and I2C slave, busy flags, transmit routing
//
// Contract
// - Module is SPI slave, host clocks
// - Select low frames one command, opcode first
// - Opcodes 44h write, 54h read, 58h status
// - Write bytes after opcode go to receive
// - Read sends 00h then transmit data
// - Reported count released, unread bytes dropped
// - Status byte repeated, latest value each byte
// - Status: busy b7, zero b6, count capped 63
// - Status with bit 6 set is invalid
// - Straps pick I2C address 50h to 53h
// - General call address never acknowledged
// - I2C to 400 kbps, ack, may stretch
// - Stretch clock while command is processed
// - Empty transmit buffer reads as FFh
// - Master acks bytes, nacks last, stops
// - After reset, responses go to serial
// - USB bulk IN selects USB transmit
// - Serial data after USB returns to serial
// - Selection cleared by reset or setup exit
// - Reset, then initialisation delay before data
// - Outputs released during reset and initialisation
// - Busy hysteresis 54/128 SPI, 62/100 I2C
// - Transmit pending high when buffer nonempty
`include "serial_port_consts.vh"
module serial_host_port #(
   parameter INIT_CYCLES = `INIT_CYCLES
) (
   input  wire       mclk,
   input  wire       reset,
   input  wire       reset_n_pin,
   input  wire       i2c_mode,
   input  wire       addr_strap_lo,
   input  wire       addr_strap_hi,
   input  wire       sck_in,
   input  wire       ssel_n_in,
   input  wire       mosi_in,
   output reg        miso_out,
   output wire       miso_oe_n,
   input  wire       sda_in,
   output wire       sda_out,
   output wire       sda_oe_n,
   output wire       scl_out,
   output wire       scl_oe_n,
   output wire       rx_busy_out,
   output wire       rx_busy_oe_n,
   output wire       tx_pending_out,
   output wire       tx_pending_oe_n,
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   input  wire       rx_pop,
   input  wire [11:0] rx_used,
   input  wire [7:0] tx_data,
   input  wire       tx_push,
   output wire       tx_full,
   input  wire       cmd_active,
   input  wire       usb_active,
   input  wire       usb_bulk_in,
   input  wire       setup_exit,
   output reg        tx_to_usb
);
   localparam TXW = 7;
   // Two-stage synchronisers for every pin input except i2c_mode
   reg [1:0] sck_s, ss_s, mosi_s, sda_s, rst_s, j0_s, j1_s;
   reg       sck_d, sda_d;
   always @(posedge mclk) begin
      sck_s  <= {sck_s[0], sck_in};
      ss_s   <= {ss_s[0], ssel_n_in};
      mosi_s <= {mosi_s[0], mosi_in};
      sda_s  <= {sda_s[0], sda_in};
      rst_s  <= {rst_s[0], reset_n_pin};
      j0_s   <= {j0_s[0], addr_strap_lo};
      j1_s   <= {j1_s[0], addr_strap_hi};
      sck_d  <= sck_s[1];
      sda_d  <= sda_s[1];
   end
   wire sck_rise = sck_s[1] & ~sck_d;
   wire sck_fall = ~sck_s[1] & sck_d;
   wire sel      = ~ss_s[1];
   wire ext_rst  = reset | ~rst_s[1];
   // Initialisation counter; outputs released until done
   reg [31:0] init_cnt_r;
   wire       ready_r = (init_cnt_r == 32'd0);
   always @(posedge mclk) begin
      if (ext_rst)
         init_cnt_r <= INIT_CYCLES;
      else if (!ready_r)
         init_cnt_r <= init_cnt_r - 32'd1;
   end
   // Transmit buffer, flip-flop storage
   reg [7:0]     tx_mem [0:`TX_DEPTH-1];
   reg [TXW-1:0] tx_wp_r, tx_rp_r, tx_cnt_r;
   wire          tx_pop;
   wire          tx_drop;
   reg  [TXW-1:0] tx_drop_n_r;
   assign tx_full = (tx_cnt_r == `TX_DEPTH);
   wire tx_wr = tx_push & ~tx_full;
   wire [TXW-1:0] tl_cap = (tx_cnt_r > `TL_MAX) ? `TL_MAX : tx_cnt_r;
   always @(posedge mclk) begin
      if (ext_rst) begin
         tx_wp_r  <= 7'd0;
         tx_rp_r  <= 7'd0;
         tx_cnt_r <= 7'd0;
      end else begin
         if (tx_wr) begin
            tx_mem[tx_wp_r] <= tx_data;
            tx_wp_r <= (tx_wp_r == `TX_DEPTH-1) ? 7'd0 : tx_wp_r + 7'd1;
         end
         if (tx_drop) begin
            tx_rp_r  <= (tx_rp_r + tx_drop_n_r >= `TX_DEPTH) ?
                        tx_rp_r + tx_drop_n_r - 7'd127 : tx_rp_r + tx_drop_n_r;
            tx_cnt_r <= tx_cnt_r - tx_drop_n_r + {6'd0, tx_wr};
         end else begin
            if (tx_pop)
               tx_rp_r <= (tx_rp_r == `TX_DEPTH-1) ? 7'd0 : tx_rp_r + 7'd1;
            tx_cnt_r <= tx_cnt_r + {6'd0, tx_wr} - {6'd0, tx_pop};
         end
      end
   end
   wire [7:0] tx_head = (tx_cnt_r == 7'd0) ? `EMPTY_READ_BYTE : tx_mem[tx_rp_r];
   // Busy flag with hysteresis on free space
   reg  busy_r;
   wire [11:0] free = 12'd2047 - rx_used;
   always @(posedge mclk) begin
      if (ext_rst || !ready_r)
         busy_r <= 1'b1;
      else if (!i2c_mode) begin
         if (free <= `SPI_BUSY_AT) busy_r <= 1'b1;
         else if (free >= `SPI_READY_AT) busy_r <= 1'b0;
      end else begin
         if (free <= `I2C_BUSY_AT) busy_r <= 1'b1;
         else if (free >= `I2C_READY_AT) busy_r <= 1'b0;
      end
   end
   wire [7:0] status = {busy_r, 1'b0, tl_cap[5:0]};
   assign rx_busy_out     = busy_r;
   assign tx_pending_out  = (tx_cnt_r != 7'd0);
   assign rx_busy_oe_n    = ~ready_r;
   assign tx_pending_oe_n = ~ready_r;
   // SPI slave, mode 0, MSB first
   localparam SP_OP = 4'b0001, SP_WR = 4'b0010, SP_RD = 4'b0100,
              SP_ST = 4'b1000;
   reg [3:0] sp_st_r;
   reg [2:0] sp_bit_r;
   reg [7:0] sp_sh_r, sp_tx_r;
   reg       sp_first_r;
   reg [TXW-1:0] sp_left_r;
   wire sp_byte = sel & sck_rise & (sp_bit_r == 3'd7);
   wire [7:0] sp_in = {sp_sh_r[6:0], mosi_s[1]};
   assign miso_oe_n = ~(ready_r & sel & ~i2c_mode);
   always @(posedge mclk) begin
      if (ext_rst || !sel || i2c_mode) begin
         sp_st_r <= SP_OP;
         sp_bit_r <= 3'd0;
         sp_sh_r <= 8'h00;
         sp_tx_r <= 8'h00;
         sp_first_r <= 1'b1;
         miso_out <= 1'b1;
      end else begin
         if (sck_rise) begin
            sp_sh_r <= sp_in;
            sp_bit_r <= sp_bit_r + 3'd1;
         end
         if (sck_fall)
            {miso_out, sp_tx_r} <= {sp_tx_r, 1'b0};
         if (sp_byte) begin
            case (sp_st_r)
               SP_OP: begin
                  if (sp_in == `OP_WRITE) sp_st_r <= SP_WR;
                  else if (sp_in == `OP_READ) begin
                     sp_st_r <= SP_RD;
                     sp_tx_r <= `READ_LEAD_BYTE;
                  end else if (sp_in == `OP_STATUS) begin
                     sp_st_r <= SP_ST;
                     sp_tx_r <= status;
                  end
               end
               SP_RD: sp_tx_r <= tx_head;
               SP_ST: sp_tx_r <= status;
               SP_WR: sp_st_r <= SP_WR;
               default: sp_st_r <= SP_OP;
            endcase
            sp_first_r <= 1'b0;
         end
      end
   end
   // Read consumes bytes; at deselect the rest of the count is dropped
   reg sel_d, in_rd_r;
   always @(posedge mclk) begin
      sel_d <= sel;
      if (ext_rst) begin
         in_rd_r <= 1'b0;
         sp_left_r <= 7'd0;
         tx_drop_n_r <= 7'd0;
      end else if (sp_byte && sp_st_r == SP_OP && sp_in == `OP_READ) begin
         in_rd_r <= 1'b1;
         sp_left_r <= tl_cap;
      end else if (sp_byte && sp_st_r == SP_RD && sp_left_r != 7'd0
                   && tx_cnt_r != 7'd0) begin
         sp_left_r <= sp_left_r - 7'd1;
      end else if (!sel && sel_d && in_rd_r) begin
         in_rd_r <= 1'b0;
         tx_drop_n_r <= (sp_left_r > tx_cnt_r) ? tx_cnt_r : sp_left_r;
      end else
         tx_drop_n_r <= 7'd0;
   end
   assign tx_drop = (tx_drop_n_r != 7'd0);
   wire sp_pop = sp_byte & (sp_st_r == SP_RD) & (sp_left_r != 7'd0)
                 & (tx_cnt_r != 7'd0);
   // I2C slave
   localparam I_IDLE = 5'b00001, I_ADDR = 5'b00010, I_WR = 5'b00100,
              I_RD = 5'b01000, I_ACK = 5'b10000;
   reg [4:0] i_st_r;
   reg [3:0] i_bit_r;
   reg [7:0] i_sh_r;
   reg       i_drv_r, i_sda_r, i_rdmode_r, i_hold_r, i_ackrd_r;
   wire scl_h  = sck_s[1];
   wire i_start = i2c_mode & scl_h & sda_d & ~sda_s[1];
   wire i_stop  = i2c_mode & scl_h & ~sda_d & sda_s[1];
   wire [6:0] my_addr = `I2C_ADDR_BASE | {5'd0, ~j1_s[1], ~j0_s[1]};
   wire [7:0] i_in = {i_sh_r[6:0], sda_s[1]};
   wire i_pop = i2c_mode & (i_st_r == I_RD) & sck_rise & (i_bit_r == 4'd7)
                & (tx_cnt_r != 7'd0);
   assign tx_pop = sp_pop | i_pop;
   // Stretch only in the SCL low phase; pulling a high SCL fakes an edge
   assign scl_out  = 1'b0;
   assign scl_oe_n = ~(ready_r & i2c_mode & i_hold_r & cmd_active
                       & ~scl_h);
   assign sda_out  = i_sda_r;
   assign sda_oe_n = ~(ready_r & i2c_mode & i_drv_r);
   reg i_wr_byte;
   always @(posedge mclk) begin
      i_wr_byte <= 1'b0;
      if (ext_rst || !i2c_mode || i_stop) begin
         i_st_r <= I_IDLE;
         i_drv_r <= 1'b0;
         i_sda_r <= 1'b1;
         i_bit_r <= 4'd0;
         i_hold_r <= 1'b0;
         i_sh_r <= 8'h00;
         i_rdmode_r <= 1'b0;
         i_ackrd_r <= 1'b0;
      end else if (i_start) begin
         i_st_r <= I_ADDR;
         i_bit_r <= 4'd0;
         i_drv_r <= 1'b0;
      end else begin
         if (!cmd_active) i_hold_r <= 1'b0;
         case (i_st_r)
            I_ADDR, I_WR: if (sck_rise) begin
               i_sh_r <= i_in;
               i_bit_r <= i_bit_r + 4'd1;
               if (i_bit_r == 4'd7) begin
                  if (i_st_r == I_ADDR) begin
                     // General call never matches        
                     if (i_in[7:1] == my_addr && i_in[7:1] != `I2C_GENCALL) begin
                        i_st_r <= I_ACK;
                        i_rdmode_r <= i_in[0];
                     end else
                        i_st_r <= I_IDLE;
                  end else begin
                     i_st_r <= I_ACK;
                     i_wr_byte <= 1'b1;
                     i_hold_r <= 1'b1;
                  end
               end
            end
            I_ACK: if (sck_fall) begin
               if (!i_drv_r) begin
                  i_drv_r <= 1'b1;
                  i_sda_r <= 1'b0;
               end else begin
                  i_bit_r <= 4'd0;
                  if (i_rdmode_r) begin
                     i_st_r <= I_RD;
                     i_sh_r <= tx_head;
                     i_sda_r <= tx_head[7];
                  end else begin
                     i_st_r <= I_WR;
                     i_drv_r <= 1'b0;
                  end
               end
            end
            I_RD: begin
               if (sck_rise) begin
                  i_bit_r <= i_bit_r + 4'd1;
                  if (i_bit_r == 4'd8)
                     i_ackrd_r <= ~sda_s[1];
               end
               if (sck_fall) begin
                  if (i_bit_r < 4'd8) begin
                     i_sda_r <= i_sh_r[7 - i_bit_r[2:0]];
                  end else if (i_bit_r == 4'd8) begin
                     i_drv_r <= 1'b0;
                  end else if (i_ackrd_r) begin
                     i_bit_r <= 4'd0;
                     i_drv_r <= 1'b1;
                     i_sh_r <= tx_head;
                     i_sda_r <= tx_head[7];
                  end else
                     i_st_r <= I_IDLE;
               end
            end
            default: i_st_r <= I_IDLE;
         endcase
      end
   end
   // Received data out, write bytes in order
   always @(posedge mclk) begin
      if (ext_rst || !ready_r) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else if (sp_byte && sp_st_r == SP_WR) begin
         rx_valid <= 1'b1;
         rx_data <= sp_in;
      end else if (i_wr_byte) begin
         rx_valid <= 1'b1;
         rx_data <= i_sh_r;
      end else if (rx_pop)
         rx_valid <= 1'b0;
   end
   // Transmit route: serial data after USB selection wins back
   wire ser_rx = (sp_byte & ~sp_first_r) | i_wr_byte;
   reg  sticky_r;
   always @(posedge mclk) begin
      if (ext_rst || setup_exit) begin
         tx_to_usb <= 1'b0;
         sticky_r <= 1'b0;
      end else if (ser_rx && tx_to_usb) begin
         tx_to_usb <= 1'b0;
         sticky_r <= 1'b1;
      end else if (usb_active && usb_bulk_in && !sticky_r)
         tx_to_usb <= 1'b1;
   end
endmodule

// *** bench/serial_host_port_monitor.sv ***
// Assertion checker for the serial host port
module serial_host_port_mon #(
   parameter INIT_CYCLES = 1000
) (
   input logic        mclk,
   input logic        reset,
   input logic        reset_n_pin,
   input logic        ssel_n_in,
   input logic        miso_oe_n,
   input logic        sda_oe_n,
   input logic        scl_oe_n,
   input logic        rx_busy_out,
   input logic        rx_busy_oe_n,
   input logic        tx_pending_out,
   input logic        tx_pending_oe_n,
   input logic [7:0]  rx_data,
   input logic        rx_valid,
   input logic        rx_pop,
   input logic [11:0] rx_used,
   input logic        tx_push,
   input logic        tx_full,
   input logic        usb_bulk_in,
   input logic        setup_exit,
   input logic        tx_to_usb
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   logic [11:0] init_cnt_r;
   logic        init_done;
   // Margin covers the pin synchroniser
   assign init_done = init_cnt_r >= 12'(INIT_CYCLES + 8);
   always_ff @(posedge mclk)
      if (reset || !reset_n_pin) init_cnt_r <= 12'h000;
      else if (!init_done) init_cnt_r <= init_cnt_r + 12'h001;
   sequence s_desel; ssel_n_in [*5]; endsequence
   sequence s_push; init_done && tx_push && !tx_full; endsequence
   property p_release;
      @(posedge mclk) disable iff (1'b0)
      reset |=> miso_oe_n && sda_oe_n && scl_oe_n && rx_busy_oe_n
         && tx_pending_oe_n && rx_busy_out && !tx_to_usb;
   endproperty
   a_release: assert property (p_release) else $error("driven in reset");
   property p_idle; s_desel |-> miso_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("miso driven idle");
   property p_pend; s_push |-> ##[1:3] tx_pending_out; endproperty
   a_pend: assert property (p_pend) else $error("pending not set");
   property p_usb;
      $rose(tx_to_usb) |-> $past(usb_bulk_in) || $past(usb_bulk_in, 2);
   endproperty
   a_usb: assert property (p_usb) else $error("usb select uncaused");
   property p_exit; setup_exit |-> ##[1:2] !tx_to_usb; endproperty
   a_exit: assert property (p_exit) else $error("exit kept usb");
   property p_busy_on;
      $rose(rx_busy_out) && init_done |-> rx_used >= 12'h7c9;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("busy early");
   property p_busy_off; $fell(rx_busy_out) |-> rx_used <= 12'h77f; endproperty
   a_busy_off: assert property (p_busy_off) else $error("ready early");
   property p_rx_hold;
      rx_valid && !rx_pop |=> rx_valid && $stable(rx_data);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx data lost");
endmodule

bind serial_host_port serial_host_port_mon #(.INIT_CYCLES(INIT_CYCLES)) mon (
   .mclk, .reset, .reset_n_pin, .ssel_n_in, .miso_oe_n, .sda_oe_n,
   .scl_oe_n, .rx_busy_out, .rx_busy_oe_n, .tx_pending_out,
   .tx_pending_oe_n, .rx_data, .rx_valid, .rx_pop, .rx_used, .tx_push,
   .tx_full, .usb_bulk_in, .setup_exit, .tx_to_usb
);

// *** bench/spi_host_model.sv ***
// Host SPI master model driving the port's serial pins
module spi_host_model (
   input  logic mclk,
   input  logic miso,
   output logic sck,
   output logic ssel_n,
   output logic mosi
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sck = 1'b0;
      ssel_n = 1'b1;
      mosi = 1'b1;
   end
   // Select edge, then setup gap before the first clock
   task automatic select(input logic on);
      @(posedge mclk);
      ssel_n <= ~on;
      if (!on)
         mosi <= ~mosi;
      repeat (4) @(posedge mclk);
   endtask
   // Long low phase lets the slave's synchronised output settle
   task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         mosi <= t[i];
         repeat (5) @(posedge mclk);
         r[i] = miso;
         sck <= 1'b1;
         repeat (3) @(posedge mclk);
         sck <= 1'b0;
      end
   endtask
endmodule

// *** bench/tb_top.sv ***
// Top-level bench for the serial host port with SPI host model
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0, reset = 1'b1, reset_n_pin = 1'b1;
   logic        rx_pop = 1'b0, tx_push = 1'b0, setup_exit = 1'b0;
   logic        usb_active = 1'b0, usb_bulk_in = 1'b0;
   logic [11:0] rx_used = 12'h000;
   logic [7:0]  tx_data = 8'h00;
   logic        sck_in, ssel_n_in, mosi_in, miso_out, miso_oe_n, miso_w;
   logic        sda_oe_n, scl_oe_n, rx_busy_out, rx_busy_oe_n, rx_valid;
   logic        tx_pending_out, tx_pending_oe_n, tx_to_usb;
   logic        sda_out, scl_out, tx_full;
   logic [7:0]  rx_data;
   logic [7:0]  got [0:7];
   logic [7:0]  rxq [$];
   logic [11:0] lvl [0:3] = '{12'h7c8, 12'h7c9, 12'h780, 12'h77f};
   int          err_total = 0, comparisons = 0;
   // Released line reads as its pull-up
   assign miso_w = miso_oe_n ? 1'b1 : miso_out;
   always #50 mclk = ~mclk;
   serial_host_port #(.INIT_CYCLES(5)) DUT (
      .mclk, .reset, .reset_n_pin, .i2c_mode(1'b0), .addr_strap_lo(1'b1),
      .addr_strap_hi(1'b1), .sck_in, .ssel_n_in, .mosi_in, .miso_out,
      .miso_oe_n, .sda_in(1'b1), .sda_out, .sda_oe_n, .scl_out,
      .scl_oe_n, .rx_busy_out, .rx_busy_oe_n, .tx_pending_out,
      .tx_pending_oe_n, .rx_data, .rx_valid, .rx_pop, .rx_used, .tx_data,
      .tx_push, .tx_full, .cmd_active(1'b0), .usb_active, .usb_bulk_in,
      .setup_exit, .tx_to_usb
   );
   spi_host_model host (
      .mclk, .miso(miso_w), .sck(sck_in), .ssel_n(ssel_n_in), .mosi(mosi_in)
   );
   always @(posedge mclk)
      if (rx_valid === 1'b1 && !rx_pop) begin
         rxq.push_back(rx_data);
         rx_pop <= 1'b1;
      end else
         rx_pop <= 1'b0;
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic await(input int sel, input logic want);
      for (int i = 0; i < 3000; i++) begin
         @(posedge mclk);
         if ((sel == 0 ? rx_busy_out : sel == 1 ? tx_pending_out
              : tx_to_usb) === want)
            return;
      end
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      results();
   endtask
   task automatic frame(input logic [7:0] op, input int n,
                        input logic [63:0] d);
      logic [7:0] r;
      host.select(1'b1);
      host.xbyte(op, r);
      for (int i = 0; i < n; i++) begin
         host.xbyte(i < 8 ? d[63 - 8 * i -: 8] : 8'h00, r);
         if (i < 8)
            got[i] = r;
      end
      host.select(1'b0);
   endtask
   task automatic push(input int n, input logic [7:0] step);
      for (int i = 0; i < n; i++) begin
         tx_data <= 8'(step * (i + 1));
         tx_push <= 1'b1;
         @(posedge mclk);
      end
      tx_push <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   // 0 pulses the bulk IN strobe, anything else the setup exit
   task automatic pulse(input int which);
      if (which == 0)
         usb_bulk_in <= 1'b1;
      else
         setup_exit <= 1'b1;
      @(posedge mclk);
      usb_bulk_in <= 1'b0;
      setup_exit <= 1'b0;
      @(posedge mclk);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      check({miso_oe_n, sda_oe_n, scl_oe_n, rx_busy_oe_n, tx_pending_oe_n,
             rx_busy_out, tx_to_usb, sda_out, scl_out, tx_full},
            24'h3f4);
      await(0, 1'b0);
      check(rx_busy_oe_n, 1'b0);
      $display("test reset done");
      frame(8'h44, 3, {24'ha53c81, 40'h0});
      repeat (10) @(posedge mclk);
      check(24'(rxq.size()), 24'h3);
      check({rxq[0], rxq[1], rxq[2]}, 24'ha53c81);
      $display("test write done");
      frame(8'h58, 2, 64'h0);
      check({got[0], got[1]}, 24'h0);
      push(3, 8'h11);
      check(tx_pending_out, 1'b1);
      frame(8'h58, 2, 64'h0);
      check({got[0], got[1]}, 24'h0303);
      frame(8'h54, 2, 64'h0);
      check({got[0], got[1]}, 24'h0011);
      repeat (8) @(posedge mclk);
      check(tx_pending_out, 1'b0);
      push(70, 8'h01);
      check(tx_full, 1'b0);
      frame(8'h58, 1, 64'h0);
      check(got[0], 24'h3f);
      frame(8'h54, 64, 64'h0);
      check({got[1], got[2]}, 24'h0102);
      frame(8'h58, 1, 64'h0);
      check(got[0], 24'h07);
      frame(8'h54, 8, 64'h0);
      check({got[1], got[7]}, 24'h4046);
      await(1, 1'b0);
      $display("test read done");
      for (int i = 0; i < 4; i++) begin
         rx_used <= lvl[i];
         repeat (8) @(posedge mclk);
         check(rx_busy_out, 4'h6 >> i & 4'h1);
         if (i == 2) begin
            frame(8'h58, 1, 64'h0);
            check(got[0], 24'h80);
         end
      end
      $display("test busy done");
      usb_active <= 1'b1;
      pulse(0);
      await(2, 1'b1);
      frame(8'h44, 1, 64'h5a00000000000000);
      await(2, 1'b0);
      pulse(0);
      repeat (8) @(posedge mclk);
      check(tx_to_usb, 1'b0);
      pulse(1);
      pulse(0);
      await(2, 1'b1);
      reset_n_pin <= 1'b0;
      repeat (4) @(posedge mclk);
      reset_n_pin <= 1'b1;
      repeat (2) @(posedge mclk);
      check({rx_busy_out, tx_to_usb}, 24'h2);
      await(0, 1'b0);
      $display("test usb done");
      results();
   end
endmodule
